// ---- otoh_port.sv ----
// Purpose: Serial overhead insertion port for the first STS-1 of the outbound STS-12.
// Assumes: Pins from the external logic are asynchronous to core_clk.
// Notes:   Inserted bytes are buffered in a FIFO and merged into the outbound stream.
//
// What this block and its external logic do
// RQ1: Drive a divided port clock that times every transfer on the port.
// RQ2: Replace outbound overhead bits with values supplied by external logic.
// RQ3: Replace overhead only for bytes flagged as belonging to the first STS-1.
// RQ4: Hold ready high while the port can accept external overhead bits.
// RQ5: Pulse frame marker for one port period just before the first bit.
// RQ6: External logic launches each bit on the falling port clock edge.
// RQ7: With enable and ready high, latch data at rising edge and insert it.
// RQ8: With insert enable low, nothing is sampled or inserted.
// RQ9: Ignore serial data in any port cycle with ready or enable low.
// RQ10: External logic samples ready and frame marker on every rising edge; the far model samples only the frame marker.
// RQ11: External logic drives insert enable high whenever it sees ready high; the far model drives it from far_en instead.
// RQ12: External logic may use the frame marker to align its bit sequence.
// RQ13: Bits not latched from the port pass the internal overhead unchanged.
`timescale 1ns/100ps

module otoh_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
        end
    end
endmodule

module otoh_port
    import otoh_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Serial insertion port pins
    output logic            ovh_port_clock,
    output logic            ovh_port_ready,
    output logic            ovh_frame_marker,
    input  wire logic       ovh_insert_enable,
    input  wire logic       ovh_serial_data_in,
    // Internal transmit overhead stream
    input  wire logic       tx_frame_start,
    input  wire logic       tx_toh_valid,
    input  wire logic       tx_toh_first_sts1,
    input  wire logic [7:0] tx_toh_byte,
    // Merged transmit overhead stream
    output logic            tx_out_valid,
    output logic [7:0]      tx_out_byte
);
    otoh_state_t state_q;
    otoh_state_t state_d;
    logic [3:0]  div_q;
    logic        ins_s1_q;
    logic        ins_s2_q;
    logic        dat_s1_q;
    logic        dat_s2_q;
    logic        frame_pend_q;
    logic [7:0]  bit_cnt_q;
    logic        byte_ok_q;
    logic [7:0]  shf_data_q;
    logic [7:0]  shf_mask_q;
    logic        push_q;
    logic        clk_q;
    logic        ready_q;
    logic        marker_q;
    logic        out_valid_q;
    logic [7:0]  out_byte_q;

    wire                  period_end = (div_q == DIV_LAST);
    wire                  sample_pt  = (div_q == DIV_SAMPLE);
    wire                  take_bit   = sample_pt && ready_q && ins_s2_q;
    wire                  byte_end   = (bit_cnt_q[2:0] == BYTE_BIT_LAST);
    wire                  last_bit   = (bit_cnt_q == STS1_TOH_BITS_LAST);
    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [FIFO_WIDTH-1:0] fifo_out_data;
    wire                  merge_hit  = tx_toh_valid && tx_toh_first_sts1 && fifo_out_valid;
    wire [7:0]            ext_mask   = fifo_out_data[15:8];
    wire [7:0]            ext_data   = fifo_out_data[7:0];
    wire [7:0]            merged     = (tx_toh_byte & ~ext_mask) | (ext_data & ext_mask);
    wire                  byte_ok_d  = byte_end ? fifo_in_ready : byte_ok_q;

    assign ovh_port_clock   = clk_q;
    assign ovh_port_ready   = ready_q;
    assign ovh_frame_marker = marker_q;
    assign tx_out_valid     = out_valid_q;
    assign tx_out_byte      = out_byte_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            OTOH_IDLE: begin
                if (period_end && frame_pend_q) begin
                    state_d = OTOH_MARK;
                end
            end
            OTOH_MARK: begin
                if (period_end) begin
                    state_d = OTOH_BITS;
                end
            end
            OTOH_BITS: begin
                if (period_end && last_bit) begin
                    state_d = OTOH_IDLE;
                end
            end
            default: begin
                state_d = OTOH_IDLE;
            end
        endcase
    end

    // Port clock divider: low in the first half, rising edge at mid period.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_q <= DIV_RESET;
            clk_q <= 1'b0;
        end else begin
            div_q <= period_end ? DIV_RESET : div_q + 4'h1; // RQ1
            clk_q <= (div_q == DIV_RISE - 4'h1) ? 1'b1 : (period_end ? 1'b0 : clk_q); // RQ1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ins_s1_q <= 1'b0;
            ins_s2_q <= 1'b0;
            dat_s1_q <= 1'b0;
            dat_s2_q <= 1'b0;
        end else begin
            ins_s1_q <= ovh_insert_enable;
            ins_s2_q <= ins_s1_q;
            dat_s1_q <= ovh_serial_data_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    // Frame sequencing; ready and marker change only on the falling port edge.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q      <= OTOH_IDLE;
            frame_pend_q <= 1'b0;
            bit_cnt_q    <= BIT_CNT_RESET;
            byte_ok_q    <= 1'b0;
            ready_q      <= 1'b0;
            marker_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            frame_pend_q <= tx_frame_start || (frame_pend_q && !(period_end && state_q == OTOH_IDLE));
            if (period_end) begin
                marker_q  <= (state_d == OTOH_MARK); // RQ5
                bit_cnt_q <= (state_q == OTOH_BITS && !last_bit) ? bit_cnt_q + 8'h01 : BIT_CNT_RESET;
                if (state_d == OTOH_BITS) begin
                    byte_ok_q <= (state_q == OTOH_BITS) ? byte_ok_d : fifo_in_ready;
                    ready_q   <= (state_q == OTOH_BITS) ? byte_ok_d : fifo_in_ready; // RQ4
                end else begin
                    ready_q   <= 1'b0; // RQ4
                end
            end
        end
    end

    // Bit capture and byte assembly; unsampled bits carry a clear mask.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            shf_data_q <= 8'h00;
            shf_mask_q <= 8'h00;
            push_q     <= 1'b0;
        end else begin
            push_q <= sample_pt && state_q == OTOH_BITS && byte_end && byte_ok_q;
            if (sample_pt && state_q == OTOH_BITS) begin
                shf_data_q <= {shf_data_q[6:0], take_bit & dat_s2_q}; // RQ7 RQ9
                shf_mask_q <= {shf_mask_q[6:0], take_bit}; // RQ8 RQ9
            end
        end
    end

    otoh_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   ({shf_mask_q, shf_data_q}),
        .out_valid (fifo_out_valid),
        .out_ready (merge_hit),
        .out_data  (fifo_out_data)
    );

    // Merge into the outbound overhead; other STS-1s pass through.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            out_valid_q <= 1'b0;
            out_byte_q  <= 8'h00;
        end else begin
            out_valid_q <= tx_toh_valid;
            out_byte_q  <= merge_hit ? merged : tx_toh_byte; // RQ2 RQ3 RQ13
        end
    end
endmodule

// ---- otoh_pkg.sv ----
// Purpose: Constants shared by the transmit overhead serial insertion port.
// Assumes: Core clock of 100 MHz; port clock derived from it by a divider.
// Notes:   Counts are derived from times in nanoseconds.
package otoh_pkg;
    localparam int unsigned CORE_CLK_PERIOD_NS = 10;
    localparam int unsigned PORT_CLK_PERIOD_NS = 160;
    localparam int unsigned PORT_DIV_CYCLES    = PORT_CLK_PERIOD_NS / CORE_CLK_PERIOD_NS;
    localparam logic [3:0]  DIV_LAST           = 4'(PORT_DIV_CYCLES - 1);
    localparam logic [3:0]  DIV_RISE           = 4'(PORT_DIV_CYCLES / 2);
    localparam logic [3:0]  DIV_SAMPLE         = 4'(PORT_DIV_CYCLES / 2 + 3);
    localparam logic [3:0]  DIV_RESET          = 4'h0;
    localparam logic [7:0]  STS1_TOH_BITS_LAST = 8'hD7;
    localparam logic [7:0]  BIT_CNT_RESET      = 8'h00;
    localparam logic [2:0]  BYTE_BIT_LAST      = 3'h7;
    localparam int unsigned FIFO_DEPTH         = 8;
    localparam int unsigned FIFO_WIDTH         = 16;

    typedef enum logic [2:0] {
        OTOH_IDLE = 3'b001,
        OTOH_MARK = 3'b010,
        OTOH_BITS = 3'b100
    } otoh_state_t;
endpackage

// ---- otoh_port_asserts.sv ----
// Purpose: Pin and stream assertions for otoh_port.
// Assumes: Port pins are registered on core_clk.
// Notes:   Bound to every otoh_port.
`timescale 1ns/100ps
module otoh_port_asserts (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // Port pins
    input wire logic       ovh_port_clock,
    input wire logic       ovh_port_ready,
    input wire logic       ovh_frame_marker,
    // Streams
    input wire logic       tx_toh_valid,
    input wire logic       tx_toh_first_sts1,
    input wire logic [7:0] tx_toh_byte,
    input wire logic       tx_out_valid,
    input wire logic [7:0] tx_out_byte
);
    logic [4:0] mark_cnt_q;
    wire  [4:0] mark_cnt_d = ovh_frame_marker ? mark_cnt_q + 5'h01 : 5'h00;
    always_ff @(posedge core_clk) begin
        mark_cnt_q <= rst_b ? mark_cnt_d : 5'h00;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence high_phase;
        ovh_port_clock [*7] ##1 !ovh_port_clock;
    endsequence
    sequence low_phase;
        !ovh_port_clock [*7] ##1 ovh_port_clock;
    endsequence
    clk_high_a: assert property ($rose(ovh_port_clock) |=> high_phase)
        else $error("port clock high phase wrong");
    clk_low_a: assert property ($fell(ovh_port_clock) |=> low_phase)
        else $error("port clock low phase wrong");
    ready_edge_a: assert property ($changed(ovh_port_ready) |-> $fell(ovh_port_clock))
        else $error("ready moved off falling edge");
    ready_hold_a: assert property ($rose(ovh_port_ready) |=> ovh_port_ready [*8])
        else $error("ready too short");
    marker_edge_a: assert property ($changed(ovh_frame_marker) |-> $fell(ovh_port_clock))
        else $error("marker moved off falling edge");
    marker_len_a: assert property ($fell(ovh_frame_marker) |-> mark_cnt_q == 5'h10)
        else $error("marker not one period");
    marker_excl_a: assert property (!(ovh_frame_marker && ovh_port_ready))
        else $error("marker with ready");
    out_valid_a: assert property (tx_toh_valid |=> tx_out_valid)
        else $error("byte not passed on");
    other_pass_a: assert property (tx_toh_valid && !tx_toh_first_sts1
        |=> tx_out_byte == $past(tx_toh_byte)) else $error("other byte changed");
endmodule
bind otoh_port otoh_port_asserts chk (.core_clk(core_clk), .rst_b(rst_b),
    .ovh_port_clock(ovh_port_clock), .ovh_port_ready(ovh_port_ready),
    .ovh_frame_marker(ovh_frame_marker), .tx_toh_valid(tx_toh_valid),
    .tx_toh_first_sts1(tx_toh_first_sts1), .tx_toh_byte(tx_toh_byte),
    .tx_out_valid(tx_out_valid), .tx_out_byte(tx_out_byte));

// ---- otoh_far_model.sv ----
// Purpose: External overhead source for the insertion port.
// Assumes: Byte n of a frame is 8'h5A xor n, sent MSB first.
// Notes:   far_en lets the bench keep insertion off.
`timescale 1ns/100ps
module otoh_far_model (
    // Port pins
    input  wire logic ovh_port_clock,
    input  wire logic ovh_port_ready,
    input  wire logic ovh_frame_marker,
    output logic      ovh_insert_enable,
    output logic      ovh_serial_data_in,
    // Bench control
    input  wire logic far_en
);
    logic       align_q = 1'b0;
    logic [7:0] idx = 8'h00;
    logic [7:0] cur;
    assign ovh_insert_enable = far_en;
    always @(posedge ovh_port_clock) begin
        align_q <= ovh_frame_marker;
    end
    initial begin
        ovh_serial_data_in = 1'b0;
        forever begin
            @(negedge ovh_port_clock);
            if (align_q)
                idx = 8'h00;
            cur = 8'h5A ^ {3'h0, idx[7:3]};
            ovh_serial_data_in <= cur[3'h7 - idx[2:0]];
            idx = idx + 8'h01;
        end
    end
endmodule

// ---- otoh_port_test.sv ----
// Purpose: Self-checking bench for otoh_port.
// Assumes: The far model aligns its bytes on the frame marker.
// Notes:   The driver queues expected merged bytes.
`timescale 1ns/100ps
module otoh_port_test;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       far_en = 1'b0;
    logic       tx_frame_start = 1'b0;
    logic       tx_toh_valid = 1'b0;
    logic       tx_toh_first_sts1 = 1'b0;
    logic [7:0] tx_toh_byte = 8'h00;
    wire        ovh_port_clock, ovh_port_ready, ovh_frame_marker;
    wire        ovh_insert_enable, ovh_serial_data_in, tx_out_valid;
    wire  [7:0] tx_out_byte;
    logic [7:0] exp_q[$];
    int         err_total = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    int         seed = 32'h5FA7;
    always #5 core_clk = ~core_clk;
    otoh_port uut (.core_clk(core_clk), .rst_b(rst_b), .ovh_port_clock(ovh_port_clock),
        .ovh_port_ready(ovh_port_ready), .ovh_frame_marker(ovh_frame_marker),
        .ovh_insert_enable(ovh_insert_enable), .ovh_serial_data_in(ovh_serial_data_in),
        .tx_frame_start(tx_frame_start), .tx_toh_valid(tx_toh_valid),
        .tx_toh_first_sts1(tx_toh_first_sts1), .tx_toh_byte(tx_toh_byte),
        .tx_out_valid(tx_out_valid), .tx_out_byte(tx_out_byte));
    otoh_far_model far (.ovh_port_clock(ovh_port_clock), .ovh_port_ready(ovh_port_ready),
        .ovh_frame_marker(ovh_frame_marker), .ovh_insert_enable(ovh_insert_enable),
        .ovh_serial_data_in(ovh_serial_data_in), .far_en(far_en));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic frame(input logic en);
        int n;
        far_en = en;
        @(negedge core_clk) tx_frame_start = 1'b1;
        @(negedge core_clk) tx_frame_start = 1'b0;
        for (n = 0; n < 40 && ovh_frame_marker !== 1'b1; n++)
            @(negedge core_clk);
        check("marker", {7'h00, ovh_frame_marker}, 8'h01);
        for (n = 0; n < 20 && ovh_frame_marker !== 1'b0; n++)
            @(negedge core_clk);
        check("marker_len", 8'(n), 8'h10);
        check("ready", {7'h00, ovh_port_ready}, 8'h01);
        repeat (1030) @(negedge core_clk);
        check("ready_full", {7'h00, ovh_port_ready}, 8'h00);
        repeat (2480) @(negedge core_clk);
    endtask
    task automatic stream(input logic en);
        int k;
        k = 0;
        for (int i = 0; i < 24; i++) begin
            @(negedge core_clk);
            tx_toh_valid = 1'b1;
            tx_toh_first_sts1 = (i % 3 != 2);
            tx_toh_byte = 8'($random(seed));
            if (en && tx_toh_first_sts1 && k < 8) begin
                exp_q.push_back(8'h5A ^ 8'(k));
                k++;
            end else
                exp_q.push_back(tx_toh_byte);
        end
        @(negedge core_clk) tx_toh_valid = 1'b0;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    always @(negedge core_clk) begin
        if (rst_b && tx_out_valid === 1'b1)
            check("out_byte", tx_out_byte, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        check("ready", {7'h00, ovh_port_ready}, 8'h00);
        $display("test reset done");
        frame(1'b1);
        stream(1'b1);
        $display("test insert done");
        frame(1'b0);
        stream(1'b0);
        repeat (4) @(negedge core_clk);
        $display("test bypass done");
        complete_run();
    end
endmodule
